// ==== core/hrl_pkg.sv ====
// hrl_pkg: shared constants for the binary hex record loader link
// assumes one clock domain; both ends import this package
package hrl_pkg;
  localparam logic [7:0] HRL_START_MARK = 8'h3a;
  localparam logic [7:0] HRL_TYPE_DATA = 8'h00;
  localparam logic [7:0] HRL_TYPE_END = 8'h01;
  localparam logic [7:0] HRL_TYPE_SEG = 8'h02;
  localparam logic [7:0] HRL_SEG_LEN = 8'h02;
  localparam logic [7:0] HRL_END_LEN = 8'h00;
  localparam logic [15:0] HRL_SEG_OFFSET = 16'h0000;
  localparam logic [15:0] HRL_SEG_LIMIT = 16'h2000;
  localparam int HRL_SEG_SHIFT = 4;
  localparam logic [7:0] HRL_CMD_WRITE = 8'h30;
  localparam logic [7:0] HRL_CMD_RAM = 8'h60;
  localparam logic [7:0] HRL_CMD_ERASE = 8'hf0;
  localparam logic [7:0] HRL_CMD_READ = 8'h40;
  localparam logic [7:0] HRL_CMD_ID = 8'hc0;
  localparam logic [7:0] HRL_CMD_STATUS = 8'hc3;
  localparam logic [7:0] HRL_ID_FIRST = 8'd9;
  localparam logic [7:0] HRL_ID_LAST = 8'd18;
  localparam logic [7:0] HRL_ST_FIRST = 8'd9;
  localparam logic [7:0] HRL_ST_LAST = 8'd12;
  localparam logic [15:0] HRL_FLASH_LO = 16'h8000;
  localparam logic [15:0] HRL_FLASH_HI = 16'hffff;
  localparam int HRL_FIFO_DEPTH = 16;
  typedef enum logic [7:0] {
    HRL_WAIT = 8'h01,
    HRL_LEN = 8'h02,
    HRL_OFS_HI = 8'h04,
    HRL_OFS_LO = 8'h08,
    HRL_TYPE = 8'h10,
    HRL_DATA = 8'h20,
    HRL_CSUM = 8'h40,
    HRL_IDLE = 8'h80
  } hrl_state_e;
endpackage

// ==== core/hrl_link_if.sv ====
// hrl_link_if: byte stream between controller and device, plus reply bytes
// assumes the serial framing sits outside; rx_err flags a receive error
interface hrl_link_if (input wire logic sys_clk);
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic [7:0] tx_data;
  logic tx_valid;
  modport device (input rx_data, input rx_valid, input rx_err, output tx_data, output tx_valid);
  modport ctrl (output rx_data, output rx_valid, output rx_err, input tx_data, input tx_valid);
endinterface

// ==== core/hrl_fifo.sv ====
// hrl_fifo: flip-flop fifo with valid/ready on both sides
// assumes a single clock, synchronous active-low reset
module hrl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    $error("fifo depth must be a power of two and width at least one");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      wr_ptr <= '0;
    else if (push)
      wr_ptr <= wr_ptr + 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      rd_ptr <= '0;
    else if (pop)
      rd_ptr <= rd_ptr + 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ==== core/hrl_device.sv ====
// hrl_device: record parser, store interface and operation checksum
// assumes serial bytes arrive on the link already deframed; memory is outside
module hrl_device #(
  parameter int DEPTH = hrl_pkg::HRL_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  hrl_link_if.device link,
  // command start from the command decoder
  input wire logic cmd_start,
  input wire logic [7:0] cmd_code,
  input wire logic overwrite_flag,
  // checksum feed for non-record commands (memory or transferred bytes)
  input wire logic sum_valid,
  input wire logic [7:0] sum_byte,
  input wire logic [7:0] sum_index,
  input wire logic sum_done,
  // store port toward flash or ram
  output logic [19:0] store_addr,
  output logic [7:0] store_data,
  output logic store_valid,
  input wire logic store_ready,
  // status
  output logic [15:0] op_sum,
  output logic busy,
  output logic idle_err
);
  import hrl_pkg::*;
  hrl_state_e state;
  hrl_state_e next_state;
  logic [7:0] cmd;
  logic [7:0] len;
  logic [7:0] cnt;
  logic [15:0] ofs;
  logic [7:0] rtype;
  logic [7:0] rsum;
  logic [15:0] seg;
  logic [15:0] seg_word;
  logic [2:0] reply_left;
  logic fifo_in_ready;
  logic [19:0] next_addr;
  logic rec_active;
  // only a data-record payload byte needs fifo room; header, checksum and segment payload bytes are never held back
  wire logic rx = link.rx_valid && state != HRL_IDLE && rec_active
    && (fifo_in_ready || state != HRL_DATA || rtype != HRL_TYPE_DATA);
  wire logic [7:0] b = link.rx_data;
  wire logic [7:0] sum_after = rsum + b;
  logic fmt_err;

  always_comb
  begin
    next_state = state;
    fmt_err = 1'b0;
    case (state)
      HRL_WAIT: if (b == HRL_START_MARK) next_state = HRL_LEN;
      HRL_LEN: next_state = HRL_OFS_HI;
      HRL_OFS_HI: next_state = HRL_OFS_LO;
      HRL_OFS_LO: next_state = HRL_TYPE;
      HRL_TYPE:
      begin
        if (b != HRL_TYPE_DATA && b != HRL_TYPE_END && b != HRL_TYPE_SEG)
          fmt_err = 1'b1;
        else if (b == HRL_TYPE_SEG && (len != HRL_SEG_LEN || ofs != HRL_SEG_OFFSET))
          fmt_err = 1'b1;
        else if (b == HRL_TYPE_END && len != HRL_END_LEN)
          fmt_err = 1'b1;
        else if (b == HRL_TYPE_DATA && seg > HRL_SEG_LIMIT)
          fmt_err = 1'b1;
        else if (len == 8'h00)
          next_state = HRL_CSUM;
        else
          next_state = HRL_DATA;
      end
      HRL_DATA: if (cnt == len - 8'h01) next_state = HRL_CSUM;
      HRL_CSUM:
      begin
        if (sum_after != 8'h00)
          fmt_err = 1'b1;
        else
          next_state = HRL_WAIT;
      end
      default: next_state = state;
    endcase
  end

  // records are parsed only while a write or ram load runs
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      rec_active <= 1'b0;
    else if (cmd_start)
      rec_active <= (cmd_code == HRL_CMD_WRITE || cmd_code == HRL_CMD_RAM);
    else if (rx && state == HRL_CSUM && !fmt_err && rtype == HRL_TYPE_END)
      rec_active <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      state <= HRL_WAIT;
    else if (link.rx_err && rec_active)
      state <= HRL_IDLE;
    else if (cmd_start)
      state <= HRL_WAIT;
    else if (rx)
      state <= fmt_err ? HRL_IDLE : next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      idle_err <= 1'b0;
    else if (cmd_start)
      idle_err <= 1'b0;
    else if ((link.rx_err && rec_active) || (rx && fmt_err))
      idle_err <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      len <= 8'h00;
      ofs <= 16'h0000;
      rtype <= 8'h00;
      rsum <= 8'h00;
      cnt <= 8'h00;
      seg_word <= 16'h0000;
    end
    else if (rx)
    begin
      rsum <= (state == HRL_WAIT) ? 8'h00 : sum_after;
      case (state)
        HRL_LEN: len <= b;
        HRL_OFS_HI: ofs[15:8] <= b;
        HRL_OFS_LO: ofs[7:0] <= b;
        HRL_TYPE:
        begin
          rtype <= b;
          cnt <= 8'h00;
        end
        HRL_DATA:
        begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'h00)
            seg_word[15:8] <= b;
          else
            seg_word[7:0] <= b;
        end
        default: cnt <= cnt;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn || cmd_start)
      seg <= 16'h0000;
    else if (rx && state == HRL_CSUM && !fmt_err && rtype == HRL_TYPE_SEG)
      seg <= seg_word;
  end

  assign next_addr = {seg, 4'h0} + {4'h0, ofs} + {12'h000, cnt};
  wire logic push = rx && state == HRL_DATA && rtype == HRL_TYPE_DATA;

  hrl_fifo #(.WIDTH(28), .DEPTH(DEPTH)) u_store_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_data({next_addr, b}),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data({store_addr, store_data}),
    .out_valid(store_valid),
    .out_ready(store_ready)
  );

  // payload bytes as stored during a ram load, plus external memory or transfer feed
  wire logic feed_ok = sum_valid && ((cmd == HRL_CMD_ID) ? (sum_index >= HRL_ID_FIRST && sum_index <= HRL_ID_LAST)
    : (cmd == HRL_CMD_STATUS) ? (sum_index >= HRL_ST_FIRST && sum_index <= HRL_ST_LAST) : 1'b1);
  // feed covers the erased, whole or read flash range
  wire logic store_take = store_valid && store_ready && cmd == HRL_CMD_RAM;
  wire logic [15:0] store_add = store_take ? {8'h00, store_data} : 16'h0000;
  wire logic [15:0] feed_add = feed_ok ? {8'h00, sum_byte} : 16'h0000;
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || cmd_start)
      op_sum <= 16'h0000;
    else
      op_sum <= op_sum + store_add + feed_add;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      cmd <= 8'h00;
    else if (cmd_start)
      cmd <= cmd_code;
  end

  // reply after sum_done, overwrite flag for write, then high, low
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || cmd_start || state == HRL_IDLE)
      reply_left <= 3'd0;
    else if (sum_done && !store_valid)
      reply_left <= (cmd == HRL_CMD_WRITE) ? 3'd3 : 3'd2;
    else if (reply_left != 3'd0)
      reply_left <= reply_left - 3'd1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      link.tx_valid <= 1'b0;
      link.tx_data <= 8'h00;
    end
    else
    begin
      link.tx_valid <= reply_left != 3'd0;
      link.tx_data <= (reply_left == 3'd3) ? {7'h00, overwrite_flag} : (reply_left == 3'd2) ? op_sum[15:8] : op_sum[7:0];
    end
  end

  assign busy = rec_active || store_valid || reply_left != 3'd0;
endmodule

// ==== core/hrl_ctrl.sv ====
// hrl_ctrl: controller end, sends one record byte by byte and counts reply
// assumes the user gives each record field; link carries raw binary bytes
module hrl_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  hrl_link_if.ctrl link,
  // record request
  input wire logic rec_go,
  input wire logic [7:0] rec_len,
  input wire logic [15:0] rec_ofs,
  input wire logic [7:0] rec_type,
  input wire logic [7:0] pay_data,
  output logic pay_take,
  output logic rec_busy,
  // reply
  input wire logic [2:0] reply_bytes,
  output logic [7:0] reply_data,
  output logic reply_valid
);
  import hrl_pkg::*;
  logic [2:0] phase;
  logic [7:0] cnt;
  logic [7:0] sum;
  logic [2:0] wait_left;
  logic [7:0] next_byte;
  assign rec_busy = phase != 3'd0 || wait_left != 3'd0;
  assign pay_take = phase == 3'd5;
  assign link.rx_err = 1'b0;
  always_comb
  begin
    case (phase)
      3'd1: next_byte = HRL_START_MARK;
      3'd2: next_byte = rec_len;
      3'd3: next_byte = rec_ofs[15:8];
      3'd4: next_byte = rec_ofs[7:0];
      3'd6: next_byte = rec_type;
      3'd5: next_byte = pay_data;
      3'd7: next_byte = 8'h00 - sum;
      default: next_byte = 8'h00;
    endcase
  end
  // mark, length, offset big endian, type, payload, checksum
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      phase <= 3'd0;
      cnt <= 8'h00;
      sum <= 8'h00;
    end
    else
    begin
      case (phase)
        3'd0: if (rec_go && wait_left == 3'd0) phase <= 3'd1;
        3'd1: begin sum <= 8'h00; phase <= 3'd2; end
        3'd2: begin sum <= sum + rec_len; phase <= 3'd3; end
        3'd3: begin sum <= sum + rec_ofs[15:8]; phase <= 3'd4; end
        3'd4: begin sum <= sum + rec_ofs[7:0]; phase <= 3'd6; cnt <= 8'h00; end
        3'd6: begin sum <= sum + rec_type; phase <= (rec_len == 8'h00) ? 3'd7 : 3'd5; end
        3'd5:
        begin
          sum <= sum + pay_data;
          cnt <= cnt + 8'h01;
          if (cnt == rec_len - 8'h01) phase <= 3'd7;
        end
        default: phase <= 3'd0;
      endcase
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      link.rx_valid <= 1'b0;
      link.rx_data <= 8'h00;
    end
    else
    begin
      link.rx_valid <= phase != 3'd0;
      link.rx_data <= next_byte;
    end
  end
  // after an end record stay silent until the reply bytes arrive
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      wait_left <= 3'd0;
    else if (phase == 3'd7 && rec_type == HRL_TYPE_END)
      wait_left <= reply_bytes;
    else if (link.tx_valid && wait_left != 3'd0)
      wait_left <= wait_left - 3'd1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      reply_valid <= 1'b0;
      reply_data <= 8'h00;
    end
    else
    begin
      reply_valid <= link.tx_valid;
      reply_data <= link.tx_data;
    end
  end
endmodule

// ==== testbench/hrl_link_chk.sv ====
// hrl_link_chk: checks on record bytes and reply bytes of the link
// assumes both link ends are design modules on one clock
module hrl_link_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // link
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_err,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic [8:0] cnt;
  logic [8:0] idx;
  logic [7:0] len;
  logic [15:0] ofs;
  logic [7:0] sum;
  assign idx = prev ? cnt : 9'h0;
  always_ff @(posedge sys_clk) prev <= rstn && rx_valid;
  always_ff @(posedge sys_clk) if (rx_valid) cnt <= idx + 9'h1;
  always_ff @(posedge sys_clk) if (rx_valid && idx == 9'h1) len <= rx_data;
  always_ff @(posedge sys_clk) if (rx_valid && (idx == 9'h2 || idx == 9'h3)) ofs <= {ofs[7:0], rx_data};
  // running byte sum after the mark; a good record ends at zero
  always_ff @(posedge sys_clk) if (rx_valid) sum <= (idx == 9'h0) ? 8'h0 : sum + rx_data;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_mark_first: assert property (rx_valid && !prev |-> rx_data == 8'h3a) else $error("no mark");
  a_record_sum: assert property ($fell(rx_valid) |-> sum == 8'h0) else $error("bad sum");
  a_record_size: assert property ($fell(rx_valid) |-> cnt == {1'b0, len} + 9'h6) else $error("bad size");
  a_type_known: assert property (rx_valid && idx == 9'h4 |-> rx_data <= 8'h02) else $error("bad type");
  a_end_len: assert property (rx_valid && idx == 9'h4 && rx_data == 8'h01 |-> len == 8'h0) else $error("end len");
  a_seg_len: assert property (rx_valid && idx == 9'h4 && rx_data == 8'h02 |-> len == 8'h2) else $error("seg len");
  a_seg_ofs: assert property (rx_valid && idx == 9'h4 && rx_data == 8'h02 |-> ofs == 16'h0) else $error("seg ofs");
  a_reply_run: assert property ($rose(tx_valid) |-> tx_valid [*2] ##[1:2] !tx_valid) else $error("reply run");
  a_quiet_reply: assert property (tx_valid |-> !rx_valid && !rx_err) else $error("ctrl not quiet");
endmodule

// ==== testbench/hex_record_loader_checksum_test.sv ====
// hex_record_loader_checksum_test: both link ends, a fault-driven device, store backpressure
// assumes the design files under core/ are compiled first
module hex_record_loader_checksum_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hrl_pkg::*;
  logic sys_clk = 0;
  logic rstn = 0;
  int seed = 53;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int pi = 0;
  int nb = 0;
  int n0;
  logic cmd_start = 0, cmd_b = 0, ovw = 0, sum_valid = 0, sum_done = 0, sum_done_b = 0, store_ready = 0;
  logic [7:0] cmd_code = 0, sum_byte = 0, sum_index = 0, st_data, op_sum_lo, rec_len = 0, rec_type = 0, ck;
  logic [19:0] st_addr;
  logic [15:0] op_sum, sum, o, rec_ofs = 0;
  logic st_valid, idle_err_b, rec_go = 0, pay_take, rec_busy, reply_valid, hold = 0, busy, idle_err;
  logic [2:0] reply_bytes = 3'h2;
  logic [7:0] reply_data;
  logic [7:0] pay [8] = '{default: 8'h0};
  logic [7:0] exp_q [$];
  logic [27:0] st_q [$];
  logic [7:0] codes [5] = '{HRL_CMD_ERASE, HRL_CMD_READ, HRL_CMD_ID, HRL_CMD_STATUS, HRL_CMD_WRITE};
  logic [55:0] cases [8] = '{56'h03_000000_0000_00, 56'h00_000001_0000_01, 56'h01_000002_2000_00,
    56'h02_000002_2001_00, 56'h01_000001_0000_00, 56'h02_000102_0010_00, 56'h02_000002_2000_00,
    56'h02_000002_2000_00};
  always #4 sys_clk = ~sys_clk;
  hrl_link_if link (.sys_clk(sys_clk));
  hrl_link_if link_b (.sys_clk(sys_clk));
  hrl_device u_hrl_device (.sys_clk(sys_clk), .rstn(rstn), .link(link), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .overwrite_flag(ovw), .sum_valid(sum_valid), .sum_byte(sum_byte), .sum_index(sum_index), .sum_done(sum_done),
    .store_addr(st_addr), .store_data(st_data), .store_valid(st_valid), .store_ready(store_ready),
    .op_sum(op_sum), .busy(busy), .idle_err(idle_err));
  hrl_device u_hrl_device_b (.sys_clk(sys_clk), .rstn(rstn), .link(link_b), .cmd_start(cmd_b),
    .cmd_code(cmd_code), .overwrite_flag(ovw), .sum_valid(sum_valid), .sum_byte(sum_byte), .sum_index(sum_index),
    .sum_done(sum_done_b), .store_addr(), .store_data(), .store_valid(), .store_ready(1'b1), .op_sum(), .busy(),
    .idle_err(idle_err_b));
  hrl_ctrl u_hrl_ctrl (.sys_clk(sys_clk), .rstn(rstn), .link(link), .rec_go(rec_go), .rec_len(rec_len),
    .rec_ofs(rec_ofs), .rec_type(rec_type), .pay_data(pay[pi[2:0]]), .pay_take(pay_take), .rec_busy(rec_busy),
    .reply_bytes(reply_bytes), .reply_data(reply_data), .reply_valid(reply_valid));
  hrl_link_chk u_hrl_link_chk (.sys_clk(sys_clk), .rstn(rstn), .rx_data(link.rx_data), .rx_valid(link.rx_valid),
    .rx_err(link.rx_err), .tx_data(link.tx_data), .tx_valid(link.tx_valid));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic start(input logic [7:0] c);
    cmd_code = c;
    reply_bytes = (c == HRL_CMD_WRITE) ? 3'h3 : 3'h2;
    cmd_start = 1;
    tick();
    cmd_start = 0;
  endtask
  task automatic rec(input logic [7:0] t, input logic [7:0] n, input logic [15:0] of);
    rec_type = t;
    rec_len = n;
    rec_ofs = of;
    pi = 0;
    rec_go = 1;
    tick();
    rec_go = 0;
    for (int i = 0; i < 600 && rec_busy; i++) tick();
    tick(2);
  endtask
  task automatic reply(input logic w);
    if (w) exp_q.push_back({7'h0, ovw});
    exp_q.push_back(sum[15:8]);
    exp_q.push_back(sum[7:0]);
    sum_done = 1;
    tick();
    sum_done = 0;
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) tick();
    check(exp_q.size(), 0);
    check(op_sum, sum);
  endtask
  task automatic sb(input logic [7:0] b);
    link_b.rx_data = b;
    link_b.rx_valid = 1;
    ck = ck + b;
    tick();
  endtask
  // fields: length, offset, type, two payload bytes, checksum spoiler
  task automatic rec_b(input logic [55:0] e);
    sb(HRL_START_MARK);
    ck = 0;
    sb(e[55:48]);
    sb(e[47:40]);
    sb(e[39:32]);
    sb(e[31:24]);
    if (e[55:48] > 0) sb(e[23:16]);
    if (e[55:48] > 1) sb(e[15:8]);
    sb(8'h0 - ck + e[7:0]);
    link_b.rx_valid = 0;
    tick();
  endtask
  always @(posedge sys_clk) if (pay_take) pi <= pi + 1;
  always @(posedge sys_clk) #1 store_ready = hold ? 1'b0 : 1'($random(seed));
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      wrap_up();
    end
    if (reply_valid) check(reply_data, exp_q.pop_front());
    if (st_valid && store_ready) check({st_addr, st_data}, st_q.pop_front());
    if (link_b.tx_valid) nb++;
  end
  initial
  begin
    link_b.rx_data = 0;
    link_b.rx_valid = 0;
    link_b.rx_err = 0;
    tick(3);
    rstn = 1;
    tick();
    start(HRL_CMD_RAM);
    pay[0] = 8'h20;
    pay[1] = 8'h00;
    rec(HRL_TYPE_SEG, 8'h02, 16'h0);
    sum = 0;
    for (int r = 0; r < 2; r++)
    begin
      o = $random(seed);
      for (int i = 0; i < 5 - 4 * r; i++)
      begin
        pay[i] = $random(seed);
        sum += {8'h0, pay[i]};
        st_q.push_back({20'h20000 + {4'h0, o} + 20'(i), pay[i]});
      end
      rec(HRL_TYPE_DATA, 8'(5 - 4 * r), o);
    end
    rec(HRL_TYPE_END, 8'h0, 16'h0);
    for (int i = 0; i < 400 && st_q.size() > 0; i++) tick();
    reply(0);
    foreach (codes[k])
    begin
      ovw = $random(seed);
      start(codes[k]);
      sum = 0;
      for (int i = 1; i <= 20; i++)
      begin
        sum_byte = $random(seed);
        sum_index = 8'(i);
        sum_valid = 1;
        // identity window 9..18, status window 9..12, others take every byte
        if (codes[k] == HRL_CMD_ID ? (i >= 9 && i <= 18) : (codes[k] != HRL_CMD_STATUS || (i >= 9 && i <= 12)))
          sum += {8'h0, sum_byte};
        tick();
      end
      sum_valid = 0;
      reply(codes[k] == HRL_CMD_WRITE);
    end
    cmd_code = HRL_CMD_RAM;
    for (int k = 0; k < 8; k++)
    begin
      cmd_b = 1;
      tick();
      cmd_b = 0;
      n0 = nb;
      link_b.rx_err = (k == 6);
      sb(8'h55);
      link_b.rx_err = 0;
      rec_b(cases[k]);
      rec_b(56'h01_000000_5500_00);
      rec_b(56'h00_000001_0000_00);
      check(idle_err_b, k < 7);
      sum_done_b = 1;
      tick();
      sum_done_b = 0;
      tick(8);
      check(nb - n0, (k < 7) ? 0 : 2);
    end
    // store port held: payload waits in the store fifo, unsummed, then drains in order
    start(HRL_CMD_RAM);
    hold = 1;
    o = $random(seed);
    sum = 0;
    for (int i = 0; i < 8; i++)
    begin
      pay[i] = $random(seed);
      sum += {8'h0, pay[i]};
      st_q.push_back({{4'h0, o} + 20'(i), pay[i]});
    end
    rec(HRL_TYPE_DATA, 8'h08, o);
    rec(HRL_TYPE_END, 8'h0, 16'h0);
    check(st_valid, 1'b1);
    check(busy, 1'b1);
    check(op_sum, 16'h0);
    hold = 0;
    for (int i = 0; i < 100 && st_q.size() > 0; i++) tick();
    check(st_q.size(), 0);
    reply(0);
    tick(2);
    check(busy, 1'b0);
    check(idle_err, 1'b0);
    wrap_up();
  end
endmodule
